// ===== verilog/aal_defines.vh
// constants shared by the add-and-literal execution slice
`ifndef AAL_DEFINES_VH
`define AAL_DEFINES_VH

// ****************************************
// opcode fields
// ****************************************
`define AAL_OP_ADD_IMM      8'h0f
`define AAL_OP_AND_IMM      8'h0b
`define AAL_OP_ADD_FILE     6'h09
`define AAL_OP_ADD_FILE_C   6'h08
`define AAL_DEST_BIT        9
`define AAL_BANK_BIT        8

// ****************************************
// data memory layout
// ****************************************
`define AAL_ADDR_W          12
`define AAL_BANK_W          4
`define AAL_ACCESS_SPLIT    8'h80
`define AAL_ACCESS_LO_BANK  4'h0
`define AAL_ACCESS_HI_BANK  4'hf

// ****************************************
// instruction phases, one-hot
// ****************************************
`define AAL_PH_IDLE         5'h01
`define AAL_PH_DECODE       5'h02
`define AAL_PH_READ         5'h04
`define AAL_PH_PROCESS      5'h08
`define AAL_PH_WRITE        5'h10

// ****************************************
// reset values
// ****************************************
`define AAL_RST_ACC         8'h00
`define AAL_RST_BANK        4'h0

`endif

// ===== verilog/aal_file_ram.v
// data memory of the execution slice, registered read port
`timescale 1ns/100ps
`default_nettype none

module aal_file_ram #(
   parameter AW = 12,
   parameter DW = 8
) (
   input  wire          mclk,
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data
);

   // storage, no reset: contents are undefined until written
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // ****************************************
   // read and write, one cycle read latency
   // ****************************************
   // read returns the old word when the same address is written
   always @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // aal_file_ram

`default_nettype wire

// ===== verilog/aal_alu.v
// add and literal execution slice: four instructions over accumulator and data memory
`timescale 1ns/100ps
`default_nettype none
`include "aal_defines.vh"

module aal_alu (
   input  wire        mclk,
   input  wire        reset,
   input  wire        instr_valid,
   input  wire [15:0] instr_word,
   output reg         instr_ready_q,
   output reg         instr_done_q,
   input  wire        bank_load,
   input  wire [3:0]  bank_value,
   input  wire        preload_en,
   input  wire [11:0] preload_addr,
   input  wire [7:0]  preload_data,
   output reg  [3:0]  bank_select_register_q,
   output reg  [7:0]  accumulator_q,
   output reg         negative_flag_q,
   output reg         overflow_flag_q,
   output reg         carry_flag_q,
   output reg         digit_carry_flag_q,
   output reg         zero_flag_q,
   output reg         file_wr_q,
   output reg  [11:0] file_wr_addr_q,
   output reg  [7:0]  file_wr_data_q
);

   // ****************************************
   // functions
   // ****************************************
   // 8-bit add with carry in; returns {ov, dc, c, sum}
   function [10:0] add8;
      input [7:0] a;
      input [7:0] b;
      input       cin;
      reg   [8:0] full;
      reg   [4:0] low;
      begin
         full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         add8  = {(a[7] == b[7]) && (full[7] != a[7]), low[4], full[8], full[7:0]};
      end
   endfunction

   // forms the full data address from bank bit, bank select and offset
   function [11:0] file_addr;
      input       banked;
      input [3:0] bank;
      input [7:0] offs;
      begin
         if (banked) begin
            file_addr = {bank, offs};
         end else if (offs < `AAL_ACCESS_SPLIT) begin
            file_addr = {`AAL_ACCESS_LO_BANK, offs};
         end else begin
            file_addr = {`AAL_ACCESS_HI_BANK, offs};
         end
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg  [4:0]  phase_q;            // one-hot instruction phase
   reg  [15:0] instr_q;            // instruction being executed
   reg         is_add_imm_q;       // decoded kinds
   reg         is_and_imm_q;
   reg         is_add_file_q;
   reg         is_add_file_c_q;
   reg  [7:0]  result_q;           // processed data awaiting write
   reg  [10:0] add_q;              // flags and sum from process phase
   wire [7:0]  file_rdata;         // operand from data memory
   wire [11:0] op_addr;            // operand address
   wire        to_file;            // result goes back to data memory
   wire        any_file;           // instruction uses data memory
   wire [10:0] add_res;            // adder output
   wire [7:0]  operand_b;          // second operand: immediate or file
   wire        ram_we;
   wire [11:0] ram_waddr;
   wire [7:0]  ram_wdata;

   assign any_file  = is_add_file_q | is_add_file_c_q;
   // bank bit clear selects the access bank, set uses bank select
   assign op_addr   = file_addr(instr_q[`AAL_BANK_BIT], bank_select_register_q, instr_q[7:0]);
   assign to_file   = any_file & instr_q[`AAL_DEST_BIT];
   // immediate for literal forms, memory word for file forms
   assign operand_b = any_file ? file_rdata : instr_q[7:0];
   // carry in only for the carry form, sampled before this instruction updates it
   assign add_res   = add8(accumulator_q, operand_b, is_add_file_c_q & carry_flag_q);

   // preload owns the write port only while idle, so it never collides
   assign ram_we    = (phase_q == `AAL_PH_WRITE) ? to_file : (preload_en & instr_ready_q);
   assign ram_waddr = (phase_q == `AAL_PH_WRITE) ? op_addr : preload_addr;
   assign ram_wdata = (phase_q == `AAL_PH_WRITE) ? result_q : preload_data;

   // ****************************************
   // data memory
   // ****************************************
   aal_file_ram #(
      .AW (`AAL_ADDR_W),
      .DW (8)
   ) u_ram (
      .mclk    (mclk),
      .rd_addr (op_addr),
      .rd_data (file_rdata),
      .wr_en   (ram_we),
      .wr_addr (ram_waddr),
      .wr_data (ram_wdata)
   );

   // ****************************************
   // phase sequencer
   // ****************************************
   // one instruction per five-phase cycle; unknown opcodes pass as no-ops
   always @(posedge mclk) begin
      if (reset) begin
         phase_q       <= `AAL_PH_IDLE;
         instr_ready_q <= 1'b1;
         instr_q       <= 16'h0000;
      end else begin
         case (phase_q)
            `AAL_PH_IDLE: begin
               if (instr_valid) begin
                  instr_q       <= instr_word;
                  instr_ready_q <= 1'b0;
                  phase_q       <= `AAL_PH_DECODE;
               end
            end
            `AAL_PH_DECODE: begin
               phase_q <= `AAL_PH_READ;
            end
            `AAL_PH_READ: begin
               phase_q <= `AAL_PH_PROCESS;
            end
            `AAL_PH_PROCESS: begin
               phase_q <= `AAL_PH_WRITE;
            end
            `AAL_PH_WRITE: begin
               phase_q       <= `AAL_PH_IDLE;
               instr_ready_q <= 1'b1;
            end
            default: begin
               phase_q       <= `AAL_PH_IDLE;
               instr_ready_q <= 1'b1;
            end
         endcase
      end
   end

   // ****************************************
   // decode phase
   // ****************************************
   always @(posedge mclk) begin
      if (reset) begin
         is_add_imm_q    <= 1'b0;
         is_and_imm_q    <= 1'b0;
         is_add_file_q   <= 1'b0;
         is_add_file_c_q <= 1'b0;
      end else if (phase_q == `AAL_PH_DECODE) begin
         is_add_imm_q    <= instr_q[15:8] == `AAL_OP_ADD_IMM;
         is_and_imm_q    <= instr_q[15:8] == `AAL_OP_AND_IMM;
         is_add_file_q   <= instr_q[15:10] == `AAL_OP_ADD_FILE;
         is_add_file_c_q <= instr_q[15:10] == `AAL_OP_ADD_FILE_C;
      end
   end

   // ****************************************
   // process phase
   // ****************************************
   // memory word from the read phase is valid here
   always @(posedge mclk) begin
      if (reset) begin
         result_q <= 8'h00;
         add_q    <= 11'h000;
      end else if (phase_q == `AAL_PH_PROCESS) begin
         add_q <= add_res;
         if (is_and_imm_q) begin
            result_q <= accumulator_q & instr_q[7:0];
         end else begin
            result_q <= add_res[7:0];
         end
      end
   end

   // ****************************************
   // write phase: destination and flags; bank select loads between instructions
   // ****************************************
   always @(posedge mclk) begin
      if (reset) begin
         accumulator_q          <= `AAL_RST_ACC;
         bank_select_register_q <= `AAL_RST_BANK;
         negative_flag_q        <= 1'b0;
         overflow_flag_q        <= 1'b0;
         carry_flag_q           <= 1'b0;
         digit_carry_flag_q     <= 1'b0;
         zero_flag_q            <= 1'b0;
         instr_done_q           <= 1'b0;
         file_wr_q              <= 1'b0;
         file_wr_addr_q         <= 12'h000;
         file_wr_data_q         <= 8'h00;
      end else begin
         instr_done_q <= phase_q == `AAL_PH_WRITE;
         file_wr_q    <= (phase_q == `AAL_PH_WRITE) & to_file;
         // bank select loads only between instructions, never mid-address
         if (bank_load && instr_ready_q) begin
            bank_select_register_q <= bank_value;
         end
         if (phase_q == `AAL_PH_WRITE) begin
            if (to_file) begin
               file_wr_addr_q <= op_addr;
               file_wr_data_q <= result_q;
            end else if (is_add_imm_q | is_and_imm_q | any_file) begin
               accumulator_q <= result_q;
            end
            // both operand forms: n and z
            if (is_add_imm_q | is_and_imm_q | any_file) begin
               negative_flag_q <= result_q[7];
               zero_flag_q     <= result_q == 8'h00;
            end
            // adds only: ov, dc, c
            if (is_add_imm_q | any_file) begin
               overflow_flag_q    <= add_q[10];
               digit_carry_flag_q <= add_q[9];
               carry_flag_q       <= add_q[8];
            end
         end
      end
   end

endmodule // aal_alu

`default_nettype wire

// ===== dv/aal_alu_monitor.sv
// checker of the add-and-literal slice, watching only its ports
`timescale 1ns/100ps
`default_nettype none
module aal_alu_monitor (
   input wire        mclk,
   input wire        reset,
   input wire        instr_valid,
   input wire [15:0] instr_word,
   input wire        instr_ready_q,
   input wire        instr_done_q,
   input wire [3:0]  bank_select_register_q,
   input wire [7:0]  accumulator_q,
   input wire        negative_flag_q,
   input wire        carry_flag_q,
   input wire        digit_carry_flag_q,
   input wire        zero_flag_q,
   input wire        file_wr_q,
   input wire [11:0] file_wr_addr_q,
   input wire [7:0]  file_wr_data_q
);
   // operands captured at the take edge; stable until done
   logic [15:0] w_q;
   logic [7:0]  a_q;
   logic [3:0]  b_q;
   logic        c_q;
   // result of a file add, wherever it was routed
   wire  [7:0]  res = w_q[9] ? file_wr_data_q : accumulator_q;
   always @(posedge mclk) begin
      if (instr_valid && instr_ready_q) begin
         w_q <= instr_word;
         a_q <= accumulator_q;
         b_q <= bank_select_register_q;
         c_q <= carry_flag_q;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_phase;
      instr_valid && instr_ready_q |=> !instr_ready_q [*4] ##1 (instr_ready_q && instr_done_q);
   endproperty
   a_phase: assert property (p_phase) else $error("four phase timing broken");
   property p_add_imm;
      instr_done_q && w_q[15:8] == 8'h0f |-> {carry_flag_q, accumulator_q} == a_q + w_q[7:0];
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("immediate add wrong");
   property p_dc;
      instr_done_q && w_q[15:8] == 8'h0f |-> digit_carry_flag_q == (a_q[3:0] + w_q[3:0] > 5'h0f);
   endproperty
   a_dc: assert property (p_dc) else $error("digit carry wrong");
   property p_and_imm;
      instr_done_q && w_q[15:8] == 8'h0b |-> accumulator_q == (a_q & w_q[7:0])
         && carry_flag_q == c_q && negative_flag_q == accumulator_q[7];
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
   property p_dest;
      instr_done_q && w_q[15:11] == 5'h04 |-> file_wr_q == w_q[9] && (w_q[9] || $stable(file_wr_addr_q));
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong");
   property p_bank;
      file_wr_q |-> file_wr_addr_q == (w_q[8] ? {b_q, w_q[7:0]} : {{4{w_q[7]}}, w_q[7:0]});
   endproperty
   a_bank: assert property (p_bank) else $error("file address wrong");
   property p_zn;
      instr_done_q && w_q[15:11] == 5'h04 |-> zero_flag_q == (res == 8'h00) && negative_flag_q == res[7];
   endproperty
   a_zn: assert property (p_zn) else $error("file add flags wrong");
endmodule // aal_alu_monitor
bind aal_alu aal_alu_monitor u_mon (
   .mclk                   (mclk),
   .reset                  (reset),
   .instr_valid            (instr_valid),
   .instr_word             (instr_word),
   .instr_ready_q          (instr_ready_q),
   .instr_done_q           (instr_done_q),
   .bank_select_register_q (bank_select_register_q),
   .accumulator_q          (accumulator_q),
   .negative_flag_q        (negative_flag_q),
   .carry_flag_q           (carry_flag_q),
   .digit_carry_flag_q     (digit_carry_flag_q),
   .zero_flag_q            (zero_flag_q),
   .file_wr_q              (file_wr_q),
   .file_wr_addr_q         (file_wr_addr_q),
   .file_wr_data_q         (file_wr_data_q)
);
`default_nettype wire

// ===== dv/aal_alu_test.sv
// self-checking bench of the add-and-literal slice
`timescale 1ns/100ps
`default_nettype none
module aal_alu_test;
   logic mclk = 0, reset = 1, instr_valid = 0, bank_load = 0, preload_en = 0;
   logic [15:0] instr_word = 0;
   logic [3:0]  bank_value = 0, bank_select_register_q;
   logic [11:0] preload_addr = 0, file_wr_addr_q;
   logic [7:0]  preload_data = 0, accumulator_q, file_wr_data_q, m_acc = 0;
   logic [4:0]  m_f = 0;  // model flags n, ov, c, dc, z
   logic [3:0]  m_bank = 0;
   logic instr_ready_q, instr_done_q, negative_flag_q, overflow_flag_q, carry_flag_q;
   logic digit_carry_flag_q, zero_flag_q, file_wr_q;
   int error_cnt = 0, checks = 0, cyc = 0, s;
   logic [15:0] base [4] = '{16'h0f00, 16'h0b00, 16'h2400, 16'h2000};
   logic [15:0] mask [4] = '{16'h00ff, 16'h00ff, 16'h03ff, 16'h03ff};
   // hand-picked corner words
   logic [15:0] corner [7] = '{16'h0f10, 16'h0f15, 16'h0f5b, 16'h0f80, 16'h0b00, 16'h2040, 16'h2697};
   aal_alu dut (
      .mclk                   (mclk),
      .reset                  (reset),
      .instr_valid            (instr_valid),
      .instr_word             (instr_word),
      .instr_ready_q          (instr_ready_q),
      .instr_done_q           (instr_done_q),
      .bank_load              (bank_load),
      .bank_value             (bank_value),
      .preload_en             (preload_en),
      .preload_addr           (preload_addr),
      .preload_data           (preload_data),
      .bank_select_register_q (bank_select_register_q),
      .accumulator_q          (accumulator_q),
      .negative_flag_q        (negative_flag_q),
      .overflow_flag_q        (overflow_flag_q),
      .carry_flag_q           (carry_flag_q),
      .digit_carry_flag_q     (digit_carry_flag_q),
      .zero_flag_q            (zero_flag_q),
      .file_wr_q              (file_wr_q),
      .file_wr_addr_q         (file_wr_addr_q),
      .file_wr_data_q         (file_wr_data_q)
   );
   always #20 mclk = ~mclk;
   // hang guard: the run needs under two thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         complete_run;
      end
   end
   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // expected {n, ov, c, dc, z, sum} of an add with carry in
   function logic [12:0] f_add(input logic [7:0] a, b, input logic ci);
      logic [8:0] t;
      logic [4:0] l;
      t = a + b + ci;
      l = a[3:0] + b[3:0] + ci;
      return {t[7], a[7] == b[7] && t[7] != a[7], t[8], l[4], t[7:0] == 8'h00, t[7:0]};
   endfunction
   // preload the operand if any, run one word, compare against the model
   task automatic run(input logic [15:0] w);
      logic [7:0] b;
      logic [12:0] e;
      logic [11:0] ad;
      logic fd;
      b = 8'($urandom);
      ad = w[8] ? {m_bank, w[7:0]} : {{4{w[7]}}, w[7:0]};
      fd = w[15:12] == 4'h2 && w[9];
      if (w[15:12] == 4'h2) begin
         preload_addr = ad;
         preload_data = b;
         preload_en = 1;
         @(posedge mclk) #1 preload_en = 0;
      end else b = w[7:0];
      e = f_add(m_acc, b, w[15:10] == 6'h08 && m_f[2]);
      if (w[15:8] == 8'h0b) e = {m_acc[7] & b[7], m_f[3:1], (m_acc & b) == 8'h00, m_acc & b};
      instr_word = w;
      instr_valid = 1;
      @(posedge mclk) #1 instr_valid = 0;
      repeat (4) @(posedge mclk);
      #1;
      chk(instr_done_q === 1 && instr_ready_q === 1, "late completion");
      chk({negative_flag_q, overflow_flag_q, carry_flag_q, digit_carry_flag_q,
           zero_flag_q} === e[12:8], "flags");
      chk(file_wr_q === fd, "destination");
      if (fd) chk(file_wr_addr_q === ad && file_wr_data_q === e[7:0], "file write");
      else chk(accumulator_q === e[7:0], "accumulator");
      if (!fd) m_acc = e[7:0];
      m_f = e[12:8];
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      #1 reset = 0;
      s = $urandom(70382);
      chk(accumulator_q === 0 && instr_ready_q === 1 && zero_flag_q === 0, "reset");
      // overflow, carry to zero, and keeping carry, carry consumed
      foreach (corner[i]) run(corner[i]);
      $display("test corner done");
      for (int i = 0; i < 300; i++) begin
         if (i % 8 == 0) begin
            bank_value = 4'($urandom);
            bank_load = 1;
            @(posedge mclk) #1 bank_load = 0;
            m_bank = bank_value;
            chk(bank_select_register_q === m_bank, "bank select");
         end
         s = $urandom % 4;
         run(base[s] | (16'($urandom) & mask[s]));
      end
      $display("test random done");
      complete_run;
   end
endmodule // aal_alu_test
`default_nettype wire
